/* shared/rrl_pkg.sv */
// package: register map, field codes and timing for the reply rate limiter and ident hold block
package rrl_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] THRESH_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] RATE_OFS = 4'hC;

    // control register bit positions
    localparam int CTRL_LIMIT_EN_BIT = 0;
    localparam int CTRL_GND_EN_BIT = 1;
    localparam int CTRL_IDENT_EN_BIT = 2;

    // status register bit positions
    localparam int STAT_DESENSE_BIT = 0;
    localparam int STAT_SPI_BIT = 1;
    localparam int STAT_GROUND_BIT = 2;
    localparam int STAT_OVER_BIT = 3;

    // reset values
    localparam logic [2:0] CTRL_RST = 3'h7;
    localparam logic [7:0] THRESH_RST = 8'h64;

    // limiter threshold range in replies per second
    localparam logic [7:0] THRESH_MIN = 8'h64;
    localparam logic [7:0] THRESH_MAX = 8'hC8;
    localparam int RATE_W = 9;

    // timing: clock rate in hertz, measurement window and ident hold in milliseconds
    localparam int CLK_HZ = 25000000;
    localparam int WINDOW_MS = 1000;
    localparam int SPI_HOLD_MS = 18000;
    localparam int WINDOW_CYC = (CLK_HZ / 1000) * WINDOW_MS;
    localparam int SPI_HOLD_CYC = (CLK_HZ / 1000) * SPI_HOLD_MS;

    // flight status codes
    localparam logic [2:0] FS_AIR = 3'h0;
    localparam logic [2:0] FS_GROUND = 3'h1;
    localparam logic [2:0] FS_SPI = 3'h5;
    // vertical status codes
    localparam logic VS_AIR = 1'b0;
    localparam logic VS_GROUND = 1'b1;
    // capability codes
    localparam logic [2:0] CA_GROUND = 3'h4;
    localparam logic [2:0] CA_AIR = 3'h5;
    localparam logic [2:0] CA_EITHER = 3'h6;

    // reply status fields handed to the reply formatter
    typedef struct packed {
        logic [2:0] flight_status_field;
        logic vertical_status_field;
        logic [2:0] capability_field;
    } rrl_fields_t;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rrl_bus_req_t;

endpackage

/* design/rrl_hold_timer.sv */
// module: restartable hold timer that keeps an indication up for a fixed number of cycles
`timescale 1ns/10ps
module rrl_hold_timer #(
    parameter int HOLD_CYC = 450000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic restart,
    // status
    output logic active
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    // refuse a hold the counter cannot express
    if (HOLD_CYC < 1) begin : g_chk
        $error("rrl_hold_timer: HOLD_CYC must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] left; // cycles still to hold
        logic on; // indication active
    } rrl_hold_t;

    rrl_hold_t st;
    rrl_hold_t next_st;

    // next state: a restart reloads the full period at any time
    always_comb begin
        next_st = st;
        if (restart) begin
            next_st.left = CW'(HOLD_CYC);
            next_st.on = 1'b1;
        end else if (st.left > CW'(1)) begin
            next_st.left = st.left - CW'(1);
        end else begin
            // period over: drop the indication
            next_st.left = '0;
            next_st.on = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.on;
endmodule

/* design/rrl_top.sv */
// module: reply rate limiter, ground state reporting and ident hold for a transponder
`timescale 1ns/10ps
module rrl_top
    import rrl_pkg::*;
#(
    parameter int WINDOW_CYCLES = rrl_pkg::WINDOW_CYC,
    parameter int SPI_CYCLES = rrl_pkg::SPI_HOLD_CYC,
    parameter logic [7:0] MAX_RATE = rrl_pkg::THRESH_MAX
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // register port
    input wire rrl_pkg::rrl_bus_req_t BUS_REQ,
    output logic [rrl_pkg::DATA_W-1:0] BUS_RDATA,
    // reply events from the reply generator, same clock
    input wire logic MODEC_REPLY,
    input wire logic AIR_OVERRIDE,
    // aircraft discretes, asynchronous pins
    input wire logic ON_GROUND_PIN,
    input wire logic IDENT_PIN,
    // outputs to receiver and reply formatter
    output logic ATCRBS_DESENSE,
    output rrl_pkg::rrl_fields_t REPLY_FIELDS
);
    import rrl_pkg::*;

    localparam int WC_W = $clog2(WINDOW_CYCLES + 1);

    // refuse settings the logic cannot serve
    if (WINDOW_CYCLES < 2) begin : g_chk_win
        $error("rrl_top: WINDOW_CYCLES must be at least 2");
    end
    if (MAX_RATE < THRESH_MIN || MAX_RATE > THRESH_MAX) begin : g_chk_max
        $error("rrl_top: MAX_RATE outside 100..200");
    end

    // the whole state of the block apart from the ident hold timer in u_hold
    typedef struct packed {
        logic [2:0] ctrl; // enables: limiter, ground report, ident
        logic [7:0] thresh; // replies per second limit
        logic [WC_W-1:0] win_left; // cycles left in measurement window
        logic [RATE_W-1:0] cnt; // replies counted in this window
        logic [RATE_W-1:0] last; // replies counted in last window
        logic over_last; // last window was over the limit
        logic [1:0] gnd_sync; // ground pin synchroniser
        logic [2:0] id_sync; // ident pin synchroniser plus edge stage
        logic desense; // sensitivity reduction request
        rrl_fields_t fields; // reply status fields
        logic [DATA_W-1:0] rdata; // read data
    } rrl_state_t;

    rrl_state_t st;
    rrl_state_t next_st;
    logic spi_on; // ident indication from the hold timer
    logic id_rise; // ident request edge

    // clamp a written threshold into the settable range
    function automatic logic [7:0] clamp_thresh(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v < THRESH_MIN) begin
            r = THRESH_MIN;
        end else if (v > MAX_RATE) begin
            r = MAX_RATE;
        end
        return r;
    endfunction

    // ident edge, read from the synchronised stages only
    assign id_rise = st.id_sync[1] & ~st.id_sync[2] & st.ctrl[CTRL_IDENT_EN_BIT];

    // ident hold timer
    rrl_hold_timer #(
        .HOLD_CYC(SPI_CYCLES)
    ) u_hold (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .restart(id_rise),
        .active(spi_on)
    );

    // next state
    always_comb begin
        logic ground_rep;
        logic [RATE_W-1:0] cnt_inc;
        logic over_now;
        ground_rep = 1'b0;
        cnt_inc = '0;
        over_now = 1'b0;
        next_st = st;

        // synchronisers for the aircraft discretes
        next_st.gnd_sync = {st.gnd_sync[0], ON_GROUND_PIN};
        next_st.id_sync = {st.id_sync[1:0], IDENT_PIN};

        // register writes
        if (BUS_REQ.wr) begin
            case (BUS_REQ.addr)
                CTRL_OFS: begin
                    next_st.ctrl = BUS_REQ.wdata[2:0];
                end
                THRESH_OFS: begin
                    next_st.thresh = clamp_thresh(BUS_REQ.wdata[7:0]);
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        // reply counting, one per reply event
        cnt_inc = st.cnt;
        if (MODEC_REPLY && st.cnt != {RATE_W{1'b1}}) begin
            cnt_inc = st.cnt + RATE_W'(1);
        end

        // measurement window
        if (st.win_left <= WC_W'(1)) begin
            next_st.win_left = WC_W'(WINDOW_CYCLES);
            next_st.last = cnt_inc;
            next_st.over_last = cnt_inc > RATE_W'(st.thresh);
            next_st.cnt = '0;
        end else begin
            next_st.win_left = st.win_left - WC_W'(1);
            next_st.cnt = cnt_inc;
        end

        // reduction while this or the last window is over the limit
        over_now = (cnt_inc > RATE_W'(st.thresh)) | st.over_last;
        next_st.desense = over_now & st.ctrl[CTRL_LIMIT_EN_BIT];

        // ground state, overridden to airborne when told so
        ground_rep = st.gnd_sync[1] & ~AIR_OVERRIDE;

        // status fields
        if (st.ctrl[CTRL_GND_EN_BIT]) begin
            // ground reporting enabled
            next_st.fields.vertical_status_field = ground_rep ? VS_GROUND : VS_AIR;
            next_st.fields.capability_field = ground_rep ? CA_GROUND : CA_AIR;
            next_st.fields.flight_status_field = ground_rep ? FS_GROUND : FS_AIR;
        end else begin
            // no ground reporting: airborne or either
            next_st.fields.vertical_status_field = VS_AIR;
            next_st.fields.capability_field = CA_EITHER;
            next_st.fields.flight_status_field = FS_AIR;
        end
        if (spi_on) begin
            next_st.fields.flight_status_field = FS_SPI;
        end

        // register reads, data in the next cycle only
        next_st.rdata = '0;
        if (BUS_REQ.rd) begin
            case (BUS_REQ.addr)
                CTRL_OFS: begin
                    next_st.rdata[2:0] = st.ctrl;
                end
                THRESH_OFS: begin
                    next_st.rdata[7:0] = st.thresh;
                end
                STATUS_OFS: begin
                    next_st.rdata[STAT_DESENSE_BIT] = st.desense;
                    next_st.rdata[STAT_SPI_BIT] = spi_on;
                    next_st.rdata[STAT_GROUND_BIT] = ground_rep;
                    next_st.rdata[STAT_OVER_BIT] = st.over_last;
                end
                RATE_OFS: begin
                    next_st.rdata[RATE_W-1:0] = st.last;
                end
                default: begin
                    // unmapped reads as zero
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
            st.ctrl <= CTRL_RST;
            st.thresh <= THRESH_RST;
            st.win_left <= WC_W'(WINDOW_CYCLES);
            st.fields.capability_field <= CA_AIR;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state; reduction feeds ATCRBS acceptance only
    assign ATCRBS_DESENSE = st.desense;
    assign REPLY_FIELDS = st.fields;
    assign BUS_RDATA = st.rdata;
endmodule

/* verification/rrl_checker_assertions.sv */
// checker: port relations of the rate limiter, ground report and ident hold
`timescale 1ns/10ps
module rrl_checker
    import rrl_pkg::*;
#(
    parameter int WINDOW_CYCLES = rrl_pkg::WINDOW_CYC,
    parameter int SPI_CYCLES = rrl_pkg::SPI_HOLD_CYC,
    parameter logic [7:0] MAX_RATE = rrl_pkg::THRESH_MAX
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // watched ports
    input wire rrl_pkg::rrl_bus_req_t BUS_REQ,
    input wire logic [rrl_pkg::DATA_W-1:0] BUS_RDATA,
    input wire logic MODEC_REPLY,
    input wire logic AIR_OVERRIDE,
    input wire logic ON_GROUND_PIN,
    input wire logic IDENT_PIN,
    input wire logic ATCRBS_DESENSE,
    input wire rrl_pkg::rrl_fields_t REPLY_FIELDS
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    int spi_run; // cycles the spi code has stood
    int quiet; // cycles since the last reply
    logic id_en; // ident enable as last written over the bus
    wire spi_on = REPLY_FIELDS.flight_status_field == FS_SPI;
    // run-length and quiet counters, shadow of the ident enable
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            spi_run <= 0;
            quiet <= 0;
            id_en <= CTRL_RST[CTRL_IDENT_EN_BIT];
        end else begin
            spi_run <= spi_on ? spi_run + 1 : 0;
            quiet <= MODEC_REPLY ? 0 : (quiet < 100000 ? quiet + 1 : quiet);
            if (BUS_REQ.wr && BUS_REQ.addr == CTRL_OFS) begin
                id_en <= BUS_REQ.wdata[CTRL_IDENT_EN_BIT];
            end
        end
    end
    chk_desense_cause: assert property ($rose(ATCRBS_DESENSE) |-> $past(MODEC_REPLY))
        else $error("desense rose without a reply");
    chk_desense_stands: assert property ($rose(ATCRBS_DESENSE) |=> ATCRBS_DESENSE [*8])
        else $error("desense dropped early");
    chk_desense_ends: assert property (quiet > 2 * WINDOW_CYCLES + 2 |-> !ATCRBS_DESENSE)
        else $error("desense held with no replies");
    chk_ground_codes: assert property (REPLY_FIELDS.flight_status_field == FS_GROUND |->
        REPLY_FIELDS.vertical_status_field == VS_GROUND && REPLY_FIELDS.capability_field == CA_GROUND)
        else $error("ground codes disagree");
    chk_air_codes: assert property (REPLY_FIELDS.vertical_status_field == VS_AIR |->
        REPLY_FIELDS.capability_field != CA_GROUND)
        else $error("air report with ground capability");
    chk_override_air: assert property (AIR_OVERRIDE |=> REPLY_FIELDS.vertical_status_field == VS_AIR)
        else $error("override did not force airborne");
    chk_ident_answer: assert property ($rose(IDENT_PIN) && id_en |-> ##[2:6] spi_on)
        else $error("ident not answered");
    chk_spi_restart: assert property ($rose(IDENT_PIN) && id_en |-> ##8 spi_on [*8])
        else $error("ident hold not restarted");
    chk_spi_length: assert property ($fell(spi_on) |-> spi_run >= SPI_CYCLES - 2)
        else $error("ident hold too short");
    cover property ($rose(ATCRBS_DESENSE));
    cover property (REPLY_FIELDS.flight_status_field == FS_GROUND);
    cover property ($fell(spi_on));
endmodule
bind rrl_top rrl_checker #(.WINDOW_CYCLES(WINDOW_CYCLES), .SPI_CYCLES(SPI_CYCLES), .MAX_RATE(MAX_RATE)) u_chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
    .MODEC_REPLY(MODEC_REPLY), .AIR_OVERRIDE(AIR_OVERRIDE), .ON_GROUND_PIN(ON_GROUND_PIN),
    .IDENT_PIN(IDENT_PIN), .ATCRBS_DESENSE(ATCRBS_DESENSE), .REPLY_FIELDS(REPLY_FIELDS));

/* verification/rrl_reply_gen.sv */
// partner: reply generator sending bursts of back-to-back reply events
`timescale 1ns/10ps
module rrl_reply_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // burst request
    input wire logic go,
    input wire logic [7:0] n,
    // reply events
    output logic pulse,
    output logic busy
);
    logic [7:0] left; // replies still to send
    assign pulse = left != 8'h00;
    assign busy = pulse;
    // one event per cycle, one per reply
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            left <= 8'h00;
        else if (go)
            left <= n;
        else if (pulse)
            left <= left - 8'h01;
    end
endmodule

/* verification/rrl_top_bench.sv */
// testbench: registers, limiter, ground report and ident hold
`timescale 1ns/10ps
module rrl_top_bench;
    import rrl_pkg::*;
    localparam int WIN = 1000; // short window
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    rrl_bus_req_t req = '0;
    logic [DATA_W-1:0] rdata;
    logic ovr = 1'b0;
    logic gnd = 1'b0;
    logic idnt = 1'b0;
    logic go = 1'b0;
    logic [7:0] n = 8'h00;
    logic rep, busy, desense;
    rrl_fields_t flds;
    logic [DATA_W-1:0] expq[$]; // expected read data
    logic rd_d = 1'b0; // read issued last cycle
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0; // edges since release
    logic [7:0] lf = 8'h3A; // lfsr state
    always #20 clk = ~clk;
    rrl_top #(.WINDOW_CYCLES(WIN), .SPI_CYCLES(50), .MAX_RATE(THRESH_MAX)) DUT (
        .CORE_CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .BUS_RDATA(rdata), .MODEC_REPLY(rep),
        .AIR_OVERRIDE(ovr), .ON_GROUND_PIN(gnd), .IDENT_PIN(idnt), .ATCRBS_DESENSE(desense),
        .REPLY_FIELDS(flds));
    rrl_reply_gen u_gen (.clk(clk), .rst_n(rst_n), .go(go), .n(n), .pulse(rep), .busy(busy));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] fx(input logic [2:0] f, input logic v, input logic [2:0] c);
        fx = {25'h0, f, v, c};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle; a read notes its expected data
    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        if (!w)
            expq.push_back(d);
        @(posedge clk);
    endtask
    task automatic idle();
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wait_at(input int m);
        while (cyc % WIN != m)
            @(posedge clk);
    endtask
    task automatic burst(input logic [7:0] k);
        go <= 1'b1;
        n <= k;
        @(posedge clk);
        go <= 1'b0;
        repeat (k + 1) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // read data monitor
    always @(posedge clk) begin
        cyc <= rst_n ? cyc + 1 : 0;
        if (rd_d)
            check(rdata, expq.pop_front());
        rd_d <= req.rd;
    end
    initial begin
        #800000;
        error_cnt++;
        end_sim();
    end
    initial begin
        logic [7:0] v;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(CTRL_OFS, 32'h0000_0007, 1'b0);
        bus(STATUS_OFS, 32'h0000_000F, 1'b1);
        bus(STATUS_OFS, 32'h0000_0000, 1'b0);
        bus(RATE_OFS, 32'h0000_0000, 1'b0);
        bus(4'h2, 32'h0000_0000, 1'b0);
        bus(THRESH_OFS, 32'h0000_0064, 1'b0);
        // threshold clamp, edge values then random
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lf;
            bus(THRESH_OFS, {24'h0, v}, 1'b1);
            bus(THRESH_OFS, {24'h0, v < THRESH_MIN ? THRESH_MIN : v > THRESH_MAX ? THRESH_MAX : v}, 1'b0);
        end
        bus(THRESH_OFS, 32'h0000_0064, 1'b1);
        idle();
        wait_at(10);
        burst(8'h64);
        check(desense, 1'b0);
        wait_at(10);
        burst(8'h65);
        check(desense, 1'b1);
        wait_at(20);
        bus(RATE_OFS, 32'h0000_0065, 1'b0);
        bus(STATUS_OFS, 32'h0000_0009, 1'b0);
        idle();
        wait_at(500);
        #1 check(desense, 1'b1);
        wait_at(10);
        #1 check(desense, 1'b0);
        gnd <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check(flds, fx(FS_GROUND, VS_GROUND, CA_GROUND));
        ovr <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(flds, fx(FS_AIR, VS_AIR, CA_AIR));
        ovr <= 1'b0;
        bus(CTRL_OFS, 32'h0000_0005, 1'b1);
        idle();
        repeat (2) @(posedge clk);
        #1 check(flds, fx(FS_AIR, VS_AIR, CA_EITHER));
        bus(CTRL_OFS, 32'h0000_0007, 1'b1);
        req <= '0;
        gnd <= 1'b0;
        idnt <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check(flds.flight_status_field, FS_SPI);
        idnt <= 1'b0;
        repeat (35) @(posedge clk);
        idnt <= 1'b1;
        repeat (40) @(posedge clk);
        #1 check(flds.flight_status_field, FS_SPI);
        repeat (20) @(posedge clk);
        #1 check(flds.flight_status_field, FS_AIR);
        // ident disabled: a new pin edge must not raise the indication
        bus(CTRL_OFS, 32'h0000_0003, 1'b1);
        idle();
        idnt <= 1'b0;
        repeat (3) @(posedge clk);
        idnt <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check(flds.flight_status_field, FS_AIR);
        end_sim();
    end
endmodule
